// ===== src/pasr_pkg.sv
// ==========================================================================
// Register map and field layout.
package pasr_pkg;
    localparam logic [4:0] PASR_ADDR_PARTNER = 5'h05;
    localparam logic [4:0] PASR_ADDR_EXPANSION = 5'h06;
    localparam logic [4:0] PASR_ADDR_NP_TX = 5'h07;
    localparam logic [4:0] PASR_ADDR_DEV_STATUS = 5'h1C;
    localparam logic [4:0] PASR_ADDR_SLOW_CTRL = 5'h1E;
    localparam int PASR_BIT_MORE = 15;
    localparam int PASR_BIT_ACK = 14;
    localparam int PASR_BIT_MSG = 13;
    localparam int PASR_BIT_COMPLY = 12;
    localparam int PASR_BIT_FLIP = 11;
    localparam int PASR_BIT_PDF = 4;
    localparam int PASR_BIT_LPNP = 3;
    localparam int PASR_BIT_NPABLE = 2;
    localparam int PASR_BIT_PAGEREC = 1;
    localparam int PASR_BIT_LPAN = 0;
    localparam int PASR_BIT_BADFRM = 8;
    localparam int PASR_BIT_CODE = 7;
    localparam int PASR_BIT_POL = 6;
    localparam int PASR_BIT_DISC = 5;
    localparam int PASR_BIT_UNLOCK = 4;
    localparam int PASR_BIT_FCAR = 3;
    localparam int PASR_BIT_JAM = 2;
    localparam int PASR_BIT_FASTUP = 1;
    localparam int PASR_BIT_SLOWUP = 0;
    localparam int PASR_BIT_POLEN = 3;
    localparam int PASR_BASE_FLIP_SRC = 11;
    localparam logic [15:0] PASR_ZERO16 = 16'h0000;
    localparam logic [10:0] PASR_CODE_RESET = 11'h000;
    localparam logic [3:0] PASR_RXD_CODE_VIOL = 4'h1;
    localparam logic [3:0] PASR_RXD_IDLE = 4'h0;
    localparam int PASR_NSYNC = 10;
    localparam int PASR_PIN_FAST = 9;
    localparam int PASR_PIN_NODELIM = 8;
    localparam int PASR_PIN_MANCH = 7;
    localparam int PASR_PIN_POLREV = 6;
    localparam int PASR_PIN_DISC = 5;
    localparam int PASR_PIN_UNLOCK = 4;
    localparam int PASR_PIN_FCAR = 3;
    localparam int PASR_PIN_JAM = 2;
    localparam int PASR_PIN_FASTOK = 1;
    localparam int PASR_PIN_SLOWOK = 0;
    localparam int PASR_CODE_MSB = 10;
    localparam int PASR_RSVD_HI = 12;
    localparam int PASR_RSVD_LO = 10;
    localparam logic [2:0] PASR_RSVD_ZERO = 3'h0;
endpackage

// ===== src/pasr_status_regs.sv
`timescale 1ns/1ps
// Summary of operation
// - Partner acknowledge bit set after three consistent partner pulse bursts.
// - Read-only partner ability bits for T4, fast, slow and duplex.
// - Partner fault bit shows a fault in the received base page.
// - Five-bit partner selector field exposed; standard partners give 00001.
// - Next-page view bit 15 shows more pages follow.
// - Next-page view acknowledge shows partner received our code word.
// - Next-page view shows partner message flag and comply flag.
// - Partner flip bit reported as received.
// - Eleven-bit code field: writable for transmit, read-only when received.
// - Parallel detect error latches high, cleared by reading or reset.
// - Expansion shows partner paging and negotiation capability.
// - Own paging capable bit always reads one.
// - Page arrived latches high on next page, cleared by reading.
// - Host writes more-pages bit; device sends that value.
// - Transmit register shows read-only acknowledge from code word.
// - Transmit register holds writable message and comply bits.
// - Transmit flip bit inverts previous flip; first page inverts base bit 11.
// - Slow mode missing delimiter flag latches, cleared on read or reset.
// - Slow mode code violation latches, drives error code, read clears.
// - Polarity status set on reversal with fix enabled in slow mode.
// - Fast mode disconnect, unlock, false carrier and jam flags latch high.
// - Fast and slow link-up bits, default zero.
// - Polarity fix enable control gates reversal detection and correction.
module pasr_status_regs (
    // Clock, reset, enable.
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic clkEn,
    // Management register port.
    input wire logic regRead,
    input wire logic regWrite,
    input wire logic [4:0] regAddr,
    input wire logic [15:0] regWdata,
    output logic [15:0] regRdata,
    // Negotiation engine, same clock.
    input wire logic pageStrobe,
    input wire logic pageIsNext,
    input wire logic [15:0] pageWord,
    input wire logic burstsConsistent,
    input wire logic partnerNegCapable,
    input wire logic partnerPagingCapable,
    input wire logic parallelFault,
    input wire logic linkAck,
    input wire logic baseWordBit11,
    input wire logic npSent,
    input wire logic npRestart,
    // Line pins, asynchronous.
    input wire logic fastMode,
    input wire logic noDelimiterEvt,
    input wire logic manchesterErrEvt,
    input wire logic polarityReversed,
    input wire logic disconnectEvt,
    input wire logic unlockEvt,
    input wire logic falseCarrierEvt,
    input wire logic forceJamEvt,
    input wire logic fastLinkOk,
    input wire logic slowLinkOk,
    // Outputs.
    output logic [15:0] npTxWord,
    output logic polarityCorrect,
    output logic [3:0] rxErrCode,
    output logic rxErrValid
);
    // ======================================================================
    // Synchronisers.
    localparam int NSYNC = pasr_pkg::PASR_NSYNC;
    logic [NSYNC-1:0] syncA_q;
    logic [NSYNC-1:0] syncB_q;
    logic [NSYNC-1:0] prevB_q;
    logic [NSYNC-1:0] pinsRaw;
    assign pinsRaw = {fastMode, noDelimiterEvt, manchesterErrEvt, polarityReversed,
        disconnectEvt, unlockEvt, falseCarrierEvt, forceJamEvt, fastLinkOk, slowLinkOk};
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            syncA_q <= '0;
            syncB_q <= '0;
            prevB_q <= '0;
        end else if (clkEn) begin
            syncA_q <= pinsRaw;
            syncB_q <= syncA_q;
            prevB_q <= syncB_q;
        end
    end
    logic fastS;
    logic [NSYNC-1:0] riseS;
    assign fastS = syncB_q[pasr_pkg::PASR_PIN_FAST];
    assign riseS = syncB_q & ~prevB_q;

    // ======================================================================
    // Read strobes.
    logic rdExp;
    logic rdDev;
    assign rdExp = clkEn && regRead && regAddr == pasr_pkg::PASR_ADDR_EXPANSION;
    assign rdDev = clkEn && regRead && regAddr == pasr_pkg::PASR_ADDR_DEV_STATUS;

    function automatic logic latchNext(input logic cur, input logic evt, input logic rd);
        latchNext = evt | (cur & ~rd);
    endfunction

    function automatic logic [15:0] txWord(input logic more, input logic ack,
        input logic msg, input logic comply, input logic flip, input logic [10:0] code);
        txWord = {more, ack, msg, comply, flip, code};
    endfunction

    function automatic logic modeEvt(input logic rise, input logic fast, input logic wantFast);
        modeEvt = rise & (fast == wantFast);
    endfunction

    // ======================================================================
    // Received page views.
    logic [15:0] baseView_q;
    logic [15:0] nextView_q;
    logic showNext_q;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            baseView_q <= pasr_pkg::PASR_ZERO16;
        end else if (clkEn && pageStrobe && !pageIsNext) begin
            baseView_q <= pageWord;
            baseView_q[pasr_pkg::PASR_BIT_ACK] <= burstsConsistent;
            baseView_q[pasr_pkg::PASR_RSVD_HI:pasr_pkg::PASR_RSVD_LO] <=
                pasr_pkg::PASR_RSVD_ZERO;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            nextView_q <= pasr_pkg::PASR_ZERO16;
        end else if (clkEn && pageStrobe && pageIsNext) begin
            nextView_q <= pageWord;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            showNext_q <= 1'b0;
        end else if (clkEn && pageStrobe) begin
            showNext_q <= pageIsNext;
        end
    end

    // ======================================================================
    // Expansion latches.
    logic pdf_q;
    logic pageArr_q;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pdf_q <= 1'b0;
        end else if (clkEn) begin
            pdf_q <= latchNext(pdf_q, parallelFault, rdExp);
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pageArr_q <= 1'b0;
        end else if (clkEn) begin
            pageArr_q <= latchNext(pageArr_q, pageStrobe & pageIsNext, rdExp);
        end
    end

    // ======================================================================
    // Next page transmit register.
    logic npMore_q;
    logic npMsg_q;
    logic npComply_q;
    logic npFlip_q;
    logic [10:0] npCode_q;
    logic firstNp_q;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            npMore_q <= 1'b0;
            npMsg_q <= 1'b0;
            npComply_q <= 1'b0;
            npCode_q <= pasr_pkg::PASR_CODE_RESET;
        end else if (clkEn && regWrite && regAddr == pasr_pkg::PASR_ADDR_NP_TX) begin
            npMore_q <= regWdata[pasr_pkg::PASR_BIT_MORE];
            npMsg_q <= regWdata[pasr_pkg::PASR_BIT_MSG];
            npComply_q <= regWdata[pasr_pkg::PASR_BIT_COMPLY];
            npCode_q <= regWdata[pasr_pkg::PASR_CODE_MSB:0];
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            npFlip_q <= 1'b0;
            firstNp_q <= 1'b1;
        end else if (clkEn) begin
            if (npRestart) begin
                firstNp_q <= 1'b1;
                npFlip_q <= ~baseWordBit11;
            end else if (firstNp_q) begin
                npFlip_q <= npSent ? baseWordBit11 : ~baseWordBit11;
                if (npSent) begin
                    firstNp_q <= 1'b0;
                end
            end else if (npSent) begin
                npFlip_q <= ~npFlip_q;
            end
        end
    end

    // ======================================================================
    // Slow mode control and device status.
    logic polEn_q;
    logic badFrm_q;
    logic codeViol_q;
    logic polStat_q;
    logic disc_q;
    logic unlock_q;
    logic fcar_q;
    logic jam_q;
    logic fastUp_q;
    logic slowUp_q;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            polEn_q <= 1'b0;
        end else if (clkEn && regWrite && regAddr == pasr_pkg::PASR_ADDR_SLOW_CTRL) begin
            polEn_q <= regWdata[pasr_pkg::PASR_BIT_POLEN];
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            badFrm_q <= 1'b0;
        end else if (clkEn) begin
            badFrm_q <= latchNext(badFrm_q, modeEvt(riseS[pasr_pkg::PASR_PIN_NODELIM], fastS, 1'b0), rdDev);
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            codeViol_q <= 1'b0;
        end else if (clkEn) begin
            codeViol_q <= latchNext(codeViol_q, modeEvt(riseS[pasr_pkg::PASR_PIN_MANCH], fastS, 1'b0), rdDev);
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            polStat_q <= 1'b0;
        end else if (clkEn) begin
            polStat_q <= polEn_q & ~fastS & syncB_q[pasr_pkg::PASR_PIN_POLREV];
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            disc_q <= 1'b0;
        end else if (clkEn) begin
            disc_q <= latchNext(disc_q, modeEvt(riseS[pasr_pkg::PASR_PIN_DISC], fastS, 1'b1), rdDev);
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            unlock_q <= 1'b0;
        end else if (clkEn) begin
            unlock_q <= latchNext(unlock_q, modeEvt(riseS[pasr_pkg::PASR_PIN_UNLOCK], fastS, 1'b1), rdDev);
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            fcar_q <= 1'b0;
        end else if (clkEn) begin
            fcar_q <= latchNext(fcar_q, modeEvt(riseS[pasr_pkg::PASR_PIN_FCAR], fastS, 1'b1), rdDev);
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            jam_q <= 1'b0;
        end else if (clkEn) begin
            jam_q <= latchNext(jam_q, modeEvt(riseS[pasr_pkg::PASR_PIN_JAM], fastS, 1'b1), rdDev);
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            fastUp_q <= 1'b0;
        end else if (clkEn) begin
            fastUp_q <= syncB_q[pasr_pkg::PASR_PIN_FASTOK];
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            slowUp_q <= 1'b0;
        end else if (clkEn) begin
            slowUp_q <= syncB_q[pasr_pkg::PASR_PIN_SLOWOK];
        end
    end

    // ======================================================================
    // Read data and outputs.
    logic [15:0] rdMux;
    always_comb begin
        rdMux = pasr_pkg::PASR_ZERO16;
        case (regAddr)
            pasr_pkg::PASR_ADDR_PARTNER: begin
                rdMux = showNext_q ? nextView_q : baseView_q;
            end
            pasr_pkg::PASR_ADDR_EXPANSION: begin
                rdMux[pasr_pkg::PASR_BIT_PDF] = pdf_q;
                rdMux[pasr_pkg::PASR_BIT_LPNP] = partnerPagingCapable;
                rdMux[pasr_pkg::PASR_BIT_NPABLE] = 1'b1;
                rdMux[pasr_pkg::PASR_BIT_PAGEREC] = pageArr_q;
                rdMux[pasr_pkg::PASR_BIT_LPAN] = partnerNegCapable;
            end
            pasr_pkg::PASR_ADDR_NP_TX: begin
                rdMux = txWord(npMore_q, linkAck, npMsg_q, npComply_q, npFlip_q, npCode_q);
            end
            pasr_pkg::PASR_ADDR_DEV_STATUS: begin
                rdMux[pasr_pkg::PASR_BIT_BADFRM] = badFrm_q;
                rdMux[pasr_pkg::PASR_BIT_CODE] = codeViol_q;
                rdMux[pasr_pkg::PASR_BIT_POL] = polStat_q;
                rdMux[pasr_pkg::PASR_BIT_DISC] = disc_q;
                rdMux[pasr_pkg::PASR_BIT_UNLOCK] = unlock_q;
                rdMux[pasr_pkg::PASR_BIT_FCAR] = fcar_q;
                rdMux[pasr_pkg::PASR_BIT_JAM] = jam_q;
                rdMux[pasr_pkg::PASR_BIT_FASTUP] = fastUp_q;
                rdMux[pasr_pkg::PASR_BIT_SLOWUP] = slowUp_q;
            end
            pasr_pkg::PASR_ADDR_SLOW_CTRL: begin
                rdMux[pasr_pkg::PASR_BIT_POLEN] = polEn_q;
            end
            default: begin
                rdMux = pasr_pkg::PASR_ZERO16;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            regRdata <= pasr_pkg::PASR_ZERO16;
        end else if (clkEn && regRead) begin
            regRdata <= rdMux;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            npTxWord <= pasr_pkg::PASR_ZERO16;
        end else if (clkEn) begin
            npTxWord <= txWord(npMore_q, linkAck, npMsg_q, npComply_q, npFlip_q, npCode_q);
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            polarityCorrect <= 1'b0;
        end else if (clkEn) begin
            polarityCorrect <= polEn_q & ~fastS & syncB_q[pasr_pkg::PASR_PIN_POLREV];
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rxErrValid <= 1'b0;
        end else if (clkEn) begin
            rxErrValid <= modeEvt(riseS[pasr_pkg::PASR_PIN_MANCH], fastS, 1'b0);
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rxErrCode <= pasr_pkg::PASR_RXD_IDLE;
        end else if (clkEn) begin
            rxErrCode <= modeEvt(riseS[pasr_pkg::PASR_PIN_MANCH], fastS, 1'b0) ?
                pasr_pkg::PASR_RXD_CODE_VIOL : pasr_pkg::PASR_RXD_IDLE;
        end
    end
endmodule

// ===== testbench/pasr_line_partner.sv
`timescale 1ns/1ps
// ==========
// Line side model: each event pin pulses for one link clock period.
module pasr_line_partner (
    // Event pins toward the device.
    output logic [5:0] lineEvt
);
    logic linkClk = 1'b0;
    initial lineEvt = 6'h00;
    initial begin
        #7;
        forever #160 linkClk = ~linkClk;
    end
    task automatic fire(input int idx);
        @(posedge linkClk);
        lineEvt[idx] = 1'b1;
        @(posedge linkClk);
        lineEvt[idx] = 1'b0;
    endtask
endmodule

// ===== testbench/pasr_status_regs_asserts.sv
`timescale 1ns/1ps
// ==========
// Register port checks.
module pasr_status_regs_asserts (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic resetn,
    // Watched ports.
    input wire logic clkEn,
    input wire logic regRead,
    input wire logic regWrite,
    input wire logic [4:0] regAddr,
    input wire logic [15:0] regWdata,
    input wire logic [15:0] regRdata,
    input wire logic pageStrobe,
    input wire logic pageIsNext,
    input wire logic [15:0] pageWord,
    input wire logic parallelFault,
    input wire logic [15:0] npTxWord,
    input wire logic [3:0] rxErrCode,
    input wire logic rxErrValid
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    wire rdExp = clkEn && regRead && regAddr == 5'h06;
    wire rdSt = clkEn && regRead && regAddr == 5'h1C;
    wire rdLp = clkEn && regRead && regAddr == 5'h05;
    wire npIn = clkEn && pageStrobe && pageIsNext;
    wire wrTx = clkEn && regWrite && regAddr == 5'h07;
    property p_ownNp; rdExp |=> regRdata[2]; endproperty
    a_ownNp: assert property (p_ownNp) else $error("own paging bit low");
    property p_expRes; rdExp |=> regRdata[15:5] == 11'h000; endproperty
    a_expRes: assert property (p_expRes) else $error("expansion spare bits set");
    property p_stRes; rdSt |=> regRdata[15:9] == 7'h00; endproperty
    a_stRes: assert property (p_stRes) else $error("status spare bits set");
    property p_pdf; parallelFault && rdExp ##1 !regRead ##1 rdExp |=> regRdata[4]; endproperty
    a_pdf: assert property (p_pdf) else $error("fault lost at read");
    property p_pgRec; npIn ##1 rdExp |=> regRdata[1]; endproperty
    a_pgRec: assert property (p_pgRec) else $error("page arrival not latched");
    property p_npView; npIn ##1 rdLp |=> regRdata == $past(pageWord, 2); endproperty
    a_npView: assert property (p_npView) else $error("next page view wrong");
    property p_txWr;
        wrTx |-> ##2 (npTxWord & 16'hB7FF) == ($past(regWdata, 2) & 16'hB7FF);
    endproperty
    a_txWr: assert property (p_txWr) else $error("transmit word not written");
    property p_errCode; rxErrValid |-> rxErrCode == 4'h1; endproperty
    a_errCode: assert property (p_errCode) else $error("wrong error code");
    property p_errPulse; rxErrValid |=> !rxErrValid; endproperty
    a_errPulse: assert property (p_errPulse) else $error("error code too long");
    c_npView: cover property (npIn ##1 rdLp);
    c_pdf: cover property (parallelFault && rdExp);
    c_err: cover property (rxErrValid);
endmodule
bind pasr_status_regs pasr_status_regs_asserts u_pasr_status_regs_asserts (.*);

// ===== testbench/pasr_status_regs_tb.sv
`timescale 1ns/1ps
// ==========
// Bench for the partner ability and status registers.
module pasr_status_regs_tb;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic clkEn = 1'b1, regRead = 1'b0, regWrite = 1'b0, pageStrobe = 1'b0, pageIsNext = 1'b0;
    logic burstsConsistent = 1'b0, partnerNegCapable = 1'b0, partnerPagingCapable = 1'b0;
    logic parallelFault = 1'b0, linkAck = 1'b0, baseWordBit11 = 1'b1, npSent = 1'b0;
    logic npRestart = 1'b0, fastMode = 1'b1, polarityReversed = 1'b0, fastLinkOk = 1'b0;
    logic slowLinkOk = 1'b0, polarityCorrect, rxErrValid;
    logic [4:0] regAddr = 5'h00;
    logic [15:0] regWdata = 16'h0000, pageWord = 16'h0000, regRdata, npTxWord;
    logic [3:0] rxErrCode;
    logic [5:0] lineEvt;
    int num_errors = 0, tests_run = 0, errPulses = 0;
    always @(negedge clk_sys) if (rxErrValid && rxErrCode == 4'h1) errPulses++;
    localparam logic [20:0] ROWS [6] = '{{5'h05, 16'h0000}, {5'h06, 16'h0004},
        {5'h07, 16'h0000}, {5'h1C, 16'h0000}, {5'h1E, 16'h0000}, {5'h10, 16'h0000}};
    always #20 clk_sys = ~clk_sys;
    pasr_line_partner u_pasr_line_partner (.lineEvt(lineEvt));
    pasr_status_regs u_pasr_status_regs (.*, .disconnectEvt(lineEvt[0]),
        .unlockEvt(lineEvt[1]), .falseCarrierEvt(lineEvt[2]), .forceJamEvt(lineEvt[3]),
        .noDelimiterEvt(lineEvt[4]), .manchesterErrEvt(lineEvt[5]));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    // Reads a register; a fault pulse raised with the read lasts one cycle.
    task automatic rc(input logic [4:0] a, input logic [15:0] e);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clk_sys);
        regRead <= 1'b0;
        parallelFault <= 1'b0;
        @(posedge clk_sys);
        chk(regRdata, e);
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        regWrite <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk_sys);
        regWrite <= 1'b0;
    endtask
    task automatic page(input logic [15:0] w, input logic nxt);
        pageStrobe <= 1'b1;
        pageWord <= w;
        pageIsNext <= nxt;
        @(posedge clk_sys);
        pageStrobe <= 1'b0;
    endtask
    task automatic results;
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        #100us;
        num_errors++;
        results();
    end
    initial begin
        repeat (12) @(posedge clk_sys);
        chk(regRdata, 16'h0000);
        resetn <= 1'b1;
        @(posedge clk_sys);
        foreach (ROWS[i]) rc(ROWS[i][20:16], ROWS[i][15:0]);
        burstsConsistent <= 1'b1;
        page(16'hFDE1, 1'b0);
        rc(5'h05, 16'hE1E1);
        page(16'hB9A5, 1'b1);
        rc(5'h05, 16'hB9A5);
        page(16'h4A5A, 1'b1);
        rc(5'h06, 16'h0006);
        rc(5'h06, 16'h0004);
        partnerNegCapable <= 1'b1;
        partnerPagingCapable <= 1'b1;
        parallelFault <= 1'b1;
        rc(5'h06, 16'h000D);
        rc(5'h06, 16'h001D);
        rc(5'h06, 16'h000D);
        wr(5'h07, 16'hFFFF);
        rc(5'h07, 16'hB7FF);
        chk(npTxWord, 16'hB7FF);
        linkAck <= 1'b1;
        npSent <= 1'b1;
        @(posedge clk_sys);
        npSent <= 1'b0;
        rc(5'h07, 16'hFFFF);
        npRestart <= 1'b1;
        @(posedge clk_sys);
        npRestart <= 1'b0;
        rc(5'h07, 16'hF7FF);
        clkEn <= 1'b0;
        wr(5'h07, 16'h0000);
        clkEn <= 1'b1;
        rc(5'h07, 16'hF7FF);
        wr(5'h05, 16'h0000);
        rc(5'h05, 16'h4A5A);
        wr(5'h1E, 16'h0008);
        rc(5'h1E, 16'h0008);
        fastLinkOk <= 1'b1;
        for (int i = 0; i < 5; i++) u_pasr_line_partner.fire(i);
        repeat (6) @(posedge clk_sys);
        rc(5'h1C, 16'h003E);
        rc(5'h1C, 16'h0002);
        fastMode <= 1'b0;
        fastLinkOk <= 1'b0;
        slowLinkOk <= 1'b1;
        polarityReversed <= 1'b1;
        repeat (4) @(posedge clk_sys);
        u_pasr_line_partner.fire(4);
        u_pasr_line_partner.fire(5);
        repeat (6) @(posedge clk_sys);
        chk({15'h0000, polarityCorrect}, 16'h0001);
        rc(5'h1C, 16'h01C1);
        rc(5'h1C, 16'h0041);
        chk(16'(errPulses), 16'h0001);
        wr(5'h1E, 16'h0000);
        repeat (2) @(posedge clk_sys);
        rc(5'h1C, 16'h0001);
        u_pasr_line_partner.fire(4);
        repeat (6) @(posedge clk_sys);
        resetn <= 1'b0;
        @(posedge clk_sys);
        resetn <= 1'b1;
        rc(5'h1C, 16'h0000);
        results();
    end
endmodule
